// ### msi_pkg.sv
`default_nettype none
package msi_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int BLANK_TIME_NS = 950;
  localparam int BLANK_CYC     = (BLANK_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int OFF_TIME_US   = 38;
  localparam int OFF_CYC       = (OFF_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W         = 14;

  // ---------------------------------------------------------------
  // indexer
  // ---------------------------------------------------------------
  localparam int             POS_W       = 5;
  localparam int             MAG_W       = 7;
  localparam logic [4:0]     HOME_POS    = 5'h04;
  localparam logic [4:0]     STRIDE_FULL = 5'h08;
  localparam logic [4:0]     STRIDE_HALF = 5'h04;
  localparam logic [4:0]     STRIDE_QTR  = 5'h02;
  localparam logic [4:0]     STRIDE_8TH  = 5'h01;

  typedef enum logic [1:0] {
    STEP_FULL = 2'h0,
    STEP_HALF = 2'h1,
    STEP_QTR  = 2'h2,
    STEP_8TH  = 2'h3
  } msi_step_t;

  typedef enum logic [1:0] {
    DECAY_SLOW  = 2'h0,
    DECAY_FAST  = 2'h1,
    DECAY_MIXED = 2'h2
  } msi_decay_t;

  typedef enum logic [3:0] {
    CH_IDLE  = 4'h1,
    CH_BLANK = 4'h2,
    CH_DRIVE = 4'h4,
    CH_DECAY = 4'h8
  } msi_chop_t;

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  localparam int               ADDR_W       = 4;
  localparam logic [3:0]       OFS_CTRL     = 4'h0;
  localparam logic [3:0]       OFS_MIXED    = 4'h4;
  localparam logic [3:0]       OFS_STATUS   = 4'h8;
  localparam logic [1:0]       CTRL_RST     = 2'h0;
  localparam logic [13:0]      MIXED_RST    = 14'h128e;

  // first-quadrant magnitude, index 0..8 in 11.25 degree steps
  function automatic logic [6:0] msi_quad_mag(input logic [3:0] idx);
    logic [6:0] m;
    m = 7'h00;
    case (idx)
      4'h0: m = 7'h64;
      4'h1: m = 7'h62;
      4'h2: m = 7'h5c;
      4'h3: m = 7'h53;
      4'h4: m = 7'h47;
      4'h5: m = 7'h38;
      4'h6: m = 7'h26;
      4'h7: m = 7'h14;
      default: m = 7'h00;
    endcase
    return m;
  endfunction

endpackage
`default_nettype wire

// ### msi_indexer.sv
// Notes on behaviour
// - two select bits pick full to eighth step
// - one table move per step rising edge
// - direction high forward, low reverse
// - home at 45 degrees after reset
// - home flag low only at home
// - positive value drives first terminal high
// - 32 fine positions, coarser modes skip
// - first quadrant sine cosine magnitudes
// - other quadrants mirror with sign changes
// - overcurrent latches bridges off until re-enable
// - overcurrent returns indexer home
// - overtemperature: drivers off, home, auto resume
// - undervoltage: all off, home, auto resume
// - clear holds home, bridges off, no steps
// - enable low drives, high floats outputs
// - indexer keeps stepping while outputs disabled
// - low power: bridges off, step, clear and overcurrent ignored; temperature and supply faults still home
// - fixed off-time chopping after trip
// - trip ignored during blanking after turn-on
// - decay select picks slow, fast or mixed
// - fast or mixed only while current falls
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// -----------------------------------------------------------------
// fixed off-time chopper for one winding
// -----------------------------------------------------------------
module msi_chopper
  import msi_pkg::*;
#(
  parameter int unsigned OFF_CYCLES = OFF_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              bridge_en,
  input  wire logic              chop_trip,
  input  wire logic              current_neg,
  input  wire logic              current_falling,
  input  wire logic [1:0]        decay_mode,
  input  wire logic [CNT_W-1:0]  fast_cycles,
  output logic                   out_pos,
  output logic                   out_neg,
  output logic                   out_pos_oe_n,
  output logic                   out_neg_oe_n
);

  localparam logic [CNT_W-1:0] BLANK_LAST = CNT_W'(BLANK_CYC - 1);
  localparam logic [CNT_W-1:0] OFF_LAST   = CNT_W'(OFF_CYCLES - 1);

  msi_chop_t         state_reg;
  msi_chop_t         state_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic              fast_now;

  // phase sequencing: blank, drive until trip, decay for off-time
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (!bridge_en) begin
      state_next = CH_IDLE;
      cnt_next   = '0;
    end else begin
      unique case (state_reg)
        CH_IDLE: begin
          state_next = CH_BLANK;
          cnt_next   = '0;
        end
        CH_BLANK: begin
          if (cnt_reg == BLANK_LAST) begin
            state_next = CH_DRIVE;
            cnt_next   = '0;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        CH_DRIVE: begin
          if (chop_trip) begin
            state_next = CH_DECAY;
            cnt_next   = '0;
          end
        end
        CH_DECAY: begin
          if (cnt_reg == OFF_LAST) begin
            state_next = CH_BLANK;
            cnt_next   = '0;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        default: begin
          state_next = CH_IDLE;
          cnt_next   = '0;
        end
      endcase
    end
  end

  // decide whether the decay phase reverses the bridge
  always_comb begin
    fast_now = 1'b0;
    if (current_falling) begin
      unique case (decay_mode)
        DECAY_FAST:  fast_now = 1'b1;
        DECAY_MIXED: fast_now = (cnt_next < fast_cycles);
        default:     fast_now = 1'b0;
      endcase
    end
  end

  // phase state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= CH_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // bridge terminals, registered from the next phase
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_pos      <= 1'b0;
      out_neg      <= 1'b0;
      out_pos_oe_n <= 1'b1;
      out_neg_oe_n <= 1'b1;
    end else if (state_next == CH_IDLE) begin
      out_pos      <= 1'b0;
      out_neg      <= 1'b0;
      out_pos_oe_n <= 1'b1;
      out_neg_oe_n <= 1'b1;
    end else if (state_next == CH_DECAY) begin
      out_pos      <= fast_now & current_neg;
      out_neg      <= fast_now & ~current_neg;
      out_pos_oe_n <= 1'b0;
      out_neg_oe_n <= 1'b0;
    end else begin
      out_pos      <= ~current_neg;
      out_neg      <= current_neg;
      out_pos_oe_n <= 1'b0;
      out_neg_oe_n <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_BLANK_IGNORES_TRIP: assert property (
    (state_reg == CH_BLANK) && bridge_en |=> state_reg != CH_DECAY)
    else $error("trip acted during blanking");

  AST_TRIP_STARTS_OFF: assert property (
    (state_reg == CH_DRIVE) && chop_trip && bridge_en
    |=> (state_reg == CH_DECAY) && (cnt_reg == '0))
    else $error("trip did not start off-time");

  AST_OFF_ENDS: assert property (
    (state_reg == CH_DECAY) && (cnt_reg == OFF_LAST) && bridge_en
    |=> state_reg == CH_BLANK)
    else $error("off-time did not end in blanking");

  AST_SLOW_WHEN_RISING: assert property (
    (state_reg == CH_DECAY) && !$past(current_falling)
    |-> !out_pos && !out_neg && !out_pos_oe_n)
    else $error("non-slow decay while current rises");

endmodule

// -----------------------------------------------------------------
// indexer, protection and register port
// -----------------------------------------------------------------
module msi_indexer
  import msi_pkg::*;
#(
  parameter int unsigned OFF_CYCLES = OFF_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              step_in,
  input  wire logic              dir_in,
  input  wire logic              step_size_sel_hi,
  input  wire logic              step_size_sel_lo,
  input  wire logic              indexer_clear_n,
  input  wire logic              drive_on_n,
  input  wire logic              low_power_n,
  input  wire logic              overcurrent_trip,
  input  wire logic              overtemp_trip,
  input  wire logic              undervoltage_trip,
  input  wire logic              chop_trip_a,
  input  wire logic              chop_trip_b,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wr_data,
  input  wire logic              reg_wr_en,
  input  wire logic              reg_rd_en,
  output logic [31:0]            reg_rd_data,
  output logic                   at_origin_flag_n,
  output logic [MAG_W-1:0]       winding_a_level,
  output logic                   winding_a_negative,
  output logic [MAG_W-1:0]       winding_b_level,
  output logic                   winding_b_negative,
  output logic                   winding_a_out_pos,
  output logic                   winding_a_out_neg,
  output logic                   winding_a_out_pos_oe_n,
  output logic                   winding_a_out_neg_oe_n,
  output logic                   winding_b_out_pos,
  output logic                   winding_b_out_neg,
  output logic                   winding_b_out_pos_oe_n,
  output logic                   winding_b_out_neg_oe_n
);

  logic [POS_W-1:0]  pos_reg;
  logic [POS_W-1:0]  pos_next;
  logic [POS_W-1:0]  stride;
  logic              step_prev_reg;
  logic              drive_prev_reg;
  logic              step_rise;
  logic              oc_latch_reg;
  logic              bridge_en;
  logic [1:0]        ctrl_reg;
  logic [CNT_W-1:0]  mixed_reg;
  logic [31:0]       status_word;
  logic [MAG_W-1:0]  lo_mag;
  logic [MAG_W-1:0]  hi_mag;
  logic [MAG_W-1:0]  mag_a;
  logic [MAG_W-1:0]  mag_b;
  logic              neg_a;
  logic              neg_b;
  logic              falling_a_reg;
  logic              falling_b_reg;

  assign step_rise = step_in & ~step_prev_reg;

  // fine positions advanced per step
  always_comb begin
    unique case (msi_step_t'({step_size_sel_hi, step_size_sel_lo}))
      STEP_FULL: stride = STRIDE_FULL;
      STEP_HALF: stride = STRIDE_HALF;
      STEP_QTR:  stride = STRIDE_QTR;
      STEP_8TH:  stride = STRIDE_8TH;
    endcase
  end

  // position: temperature and supply faults force home, else sleep freezes, else clear and overcurrent force home
  always_comb begin
    pos_next = pos_reg;
    if (overtemp_trip || undervoltage_trip) begin
      pos_next = HOME_POS;
    end else if (!low_power_n) begin
      pos_next = pos_reg;
    end else if (!indexer_clear_n || overcurrent_trip) begin
      pos_next = HOME_POS;
    end else if (step_rise) begin  // enable level not used
      // five-bit arithmetic wraps at both ends
      if (dir_in) begin
        pos_next = pos_reg + stride;
      end else begin
        pos_next = pos_reg - stride;
      end
    end
  end

  // indexer state and edge history
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pos_reg          <= HOME_POS;
      at_origin_flag_n <= 1'b0;
      step_prev_reg    <= 1'b0;
      drive_prev_reg   <= 1'b1;
    end else begin
      pos_reg          <= pos_next;
      at_origin_flag_n <= (pos_next != HOME_POS);
      step_prev_reg    <= step_in;
      drive_prev_reg   <= drive_on_n;
    end
  end

  // overcurrent latch, released by enable going high then low
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      oc_latch_reg <= 1'b0;
    end else if (overcurrent_trip && low_power_n) begin
      oc_latch_reg <= 1'b1;
    end else if (low_power_n && drive_prev_reg && !drive_on_n) begin
      oc_latch_reg <= 1'b0;
    end
  end

  // any blocker floats every bridge terminal
  assign bridge_en = low_power_n & indexer_clear_n & ~drive_on_n
                   & ~oc_latch_reg & ~overcurrent_trip
                   & ~overtemp_trip & ~undervoltage_trip;

  // table lookup by quadrant
  always_comb begin
    lo_mag = msi_quad_mag({1'b0, pos_reg[2:0]});
    hi_mag = msi_quad_mag(4'h8 - {1'b0, pos_reg[2:0]});
    unique case (pos_reg[4:3])
      2'h0: begin
        mag_a = lo_mag; neg_a = 1'b0; mag_b = hi_mag; neg_b = 1'b0;
      end
      2'h1: begin
        mag_a = hi_mag; neg_a = 1'b1; mag_b = lo_mag; neg_b = 1'b0;
      end
      2'h2: begin
        mag_a = lo_mag; neg_a = 1'b1; mag_b = hi_mag; neg_b = 1'b1;
      end
      2'h3: begin
        mag_a = hi_mag; neg_a = 1'b0; mag_b = lo_mag; neg_b = 1'b1;
      end
    endcase
  end

  // current command and its trend per winding
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      winding_a_level    <= '0;
      winding_a_negative <= 1'b0;
      winding_b_level    <= '0;
      winding_b_negative <= 1'b0;
      falling_a_reg      <= 1'b0;
      falling_b_reg      <= 1'b0;
    end else begin
      winding_a_level    <= mag_a;
      winding_a_negative <= neg_a && (mag_a != '0);
      winding_b_level    <= mag_b;
      winding_b_negative <= neg_b && (mag_b != '0);
      if (mag_a != winding_a_level) begin
        falling_a_reg <= (mag_a < winding_a_level);
      end
      if (mag_b != winding_b_level) begin
        falling_b_reg <= (mag_b < winding_b_level);
      end
    end
  end

  // -----------------------------------------------------------------
  // register port
  // -----------------------------------------------------------------

  // software writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_reg  <= CTRL_RST;
      mixed_reg <= MIXED_RST;
    end else if (reg_wr_en && (reg_addr == OFS_CTRL)) begin
      ctrl_reg <= reg_wr_data[1:0];
    end else if (reg_wr_en && (reg_addr == OFS_MIXED)) begin
      mixed_reg <= reg_wr_data[CNT_W-1:0];
    end
  end

  // status layout
  always_comb begin
    status_word      = 32'h0000_0000;
    status_word[4:0] = pos_reg;
    status_word[5]   = ~at_origin_flag_n;
    status_word[6]   = oc_latch_reg;
    status_word[7]   = bridge_en;
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rd_data <= 32'h0000_0000;
    end else if (reg_rd_en) begin
      unique case (reg_addr)
        OFS_CTRL:   reg_rd_data <= {30'h0, ctrl_reg};
        OFS_MIXED:  reg_rd_data <= {18'h0, mixed_reg};
        OFS_STATUS: reg_rd_data <= status_word;
        default:    reg_rd_data <= 32'h0000_0000;
      endcase
    end else begin
      reg_rd_data <= 32'h0000_0000;
    end
  end

  // -----------------------------------------------------------------
  // choppers
  // -----------------------------------------------------------------
  msi_chopper #(.OFF_CYCLES(OFF_CYCLES)) u_chop_a (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .bridge_en       (bridge_en),
    .chop_trip       (chop_trip_a),
    .current_neg     (winding_a_negative),
    .current_falling (falling_a_reg),
    .decay_mode      (ctrl_reg),
    .fast_cycles     (mixed_reg),
    .out_pos         (winding_a_out_pos),
    .out_neg         (winding_a_out_neg),
    .out_pos_oe_n    (winding_a_out_pos_oe_n),
    .out_neg_oe_n    (winding_a_out_neg_oe_n)
  );

  msi_chopper #(.OFF_CYCLES(OFF_CYCLES)) u_chop_b (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .bridge_en       (bridge_en),
    .chop_trip       (chop_trip_b),
    .current_neg     (winding_b_negative),
    .current_falling (falling_b_reg),
    .decay_mode      (ctrl_reg),
    .fast_cycles     (mixed_reg),
    .out_pos         (winding_b_out_pos),
    .out_neg         (winding_b_out_neg),
    .out_pos_oe_n    (winding_b_out_pos_oe_n),
    .out_neg_oe_n    (winding_b_out_neg_oe_n)
  );

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_STEP_FWD_EIGHTH: assert property (
    step_in && !step_prev_reg && dir_in && low_power_n
    && indexer_clear_n && !overcurrent_trip && !overtemp_trip
    && !undervoltage_trip && step_size_sel_hi && step_size_sel_lo
    |=> pos_reg == 5'($past(pos_reg) + 5'h01))
    else $error("eighth step forward did not advance by one");

  AST_STEP_REV_FULL: assert property (
    step_in && !step_prev_reg && !dir_in && low_power_n
    && indexer_clear_n && !overcurrent_trip && !overtemp_trip
    && !undervoltage_trip && !step_size_sel_hi && !step_size_sel_lo
    |=> pos_reg == 5'($past(pos_reg) - 5'h08))
    else $error("full step reverse did not move back by eight");

  AST_HOME_FLAG: assert property (
    !at_origin_flag_n |=> winding_a_level == 7'h47
    && winding_b_level == 7'h47 && !winding_a_negative
    && !winding_b_negative)
    else $error("home flag low away from the 45 degree entry");

  AST_TABLE_225: assert property (
    $past(pos_reg) == 5'h14 |-> winding_a_level == 7'h47
    && winding_b_level == 7'h47 && winding_a_negative
    && winding_b_negative)
    else $error("225 degree entry wrong");

  AST_TABLE_FIRST: assert property (
    $past(pos_reg) == 5'h01 |-> winding_a_level == 7'h62
    && winding_b_level == 7'h14 && !winding_a_negative
    && !winding_b_negative)
    else $error("11.25 degree entry wrong");

  AST_CLEAR_HOLDS: assert property (
    !indexer_clear_n && low_power_n && !overtemp_trip
    |=> pos_reg == HOME_POS && winding_a_out_pos_oe_n
    && winding_b_out_neg_oe_n)
    else $error("clear did not hold home with bridges off");

  AST_OVERCURRENT_HOME: assert property (
    overcurrent_trip && low_power_n |=> pos_reg == HOME_POS
    && oc_latch_reg)
    else $error("overcurrent did not home and latch");

  AST_OVERCURRENT_HOLD: assert property (
    oc_latch_reg && drive_on_n && !overcurrent_trip
    |=> oc_latch_reg)
    else $error("overcurrent latch released while enable high");

  AST_ENABLE_FLOATS: assert property (
    drive_on_n |=> winding_a_out_pos_oe_n && winding_a_out_neg_oe_n
    && winding_b_out_pos_oe_n && winding_b_out_neg_oe_n)
    else $error("outputs driven while enable high");

  AST_TEMP_HOME: assert property (
    overtemp_trip |=> pos_reg == HOME_POS && winding_a_out_pos_oe_n
    && winding_b_out_pos_oe_n)
    else $error("overtemperature did not shut down and home");

  AST_SLEEP_FREEZE: assert property (
    !low_power_n && !overtemp_trip && !undervoltage_trip
    |=> $stable(pos_reg) && winding_a_out_neg_oe_n
    && winding_b_out_neg_oe_n)
    else $error("position moved or bridge on during low power");

endmodule
`default_nettype wire

// ### msi_motion_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// motion controller model issuing step and direction
// ---------------------------------------------------------------
module msi_motion_ctrl #(
  parameter int WAKE_CYC = 8
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic req,
  input  wire logic fwd,
  input  wire logic low_power_n,
  output logic      step_in,
  output logic      dir_in,
  output logic      busy
);
  logic [2:0] cnt;
  int         wake;

  // cycles since leaving low power, restarted while asleep
  always_ff @(posedge core_clk) begin
    if (!rst_n || !low_power_n) begin
      wake <= 0;
    end else if (wake < WAKE_CYC) begin
      wake <= wake + 1;
    end
  end

  // dir set one cycle ahead, step high two cycles, low three
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt     <= 3'h0;
      step_in <= 1'b0;
      dir_in  <= 1'b1;
    end else if (cnt == 3'h0) begin
      if (req && (!low_power_n || wake == WAKE_CYC)) begin
        dir_in <= fwd;
        cnt    <= 3'h1;
      end
    end else begin
      step_in <= (cnt == 3'h1 || cnt == 3'h2);
      cnt     <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
    end
  end

  assign busy = (cnt != 3'h0);
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb import msi_pkg::*;;
  logic        core_clk = 0, rst_n = 0, req = 0, fwd = 1, rd_seen = 0;
  logic        sh = 1, sl = 1, clr_n = 1, drv_n = 1, lp_n = 1;
  logic        oc = 0, ot = 0, uv = 0, ca = 0, cb = 0, wr = 0, rd = 0;
  logic [3:0]  addr = 0;
  logic [31:0] wdat = 0, rdat, em, ev;
  logic        step, dir, busy, home_n, an, bn;
  logic        ap, aq, apo, aqo, bp, bq, bpo, bqo;
  logic [6:0]  al, bl;
  logic [31:0] exp_q[$], msk_q[$];
  int          failures = 0, n_compared = 0, seed = 26337, pos = 4, eoc = 0;
  int          mt[9] = '{100, 98, 92, 83, 71, 56, 38, 20, 0};

  always #2 core_clk = ~core_clk;

  msi_motion_ctrl ctl (.core_clk(core_clk), .rst_n(rst_n), .req(req),
    .fwd(fwd), .low_power_n(lp_n), .step_in(step), .dir_in(dir),
    .busy(busy));

  msi_indexer #(.OFF_CYCLES(20)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .step_in(step), .dir_in(dir), .step_size_sel_hi(sh),
    .step_size_sel_lo(sl), .indexer_clear_n(clr_n), .drive_on_n(drv_n),
    .low_power_n(lp_n), .overcurrent_trip(oc), .overtemp_trip(ot),
    .undervoltage_trip(uv), .chop_trip_a(ca), .chop_trip_b(cb),
    .reg_addr(addr), .reg_wr_data(wdat), .reg_wr_en(wr), .reg_rd_en(rd),
    .reg_rd_data(rdat), .at_origin_flag_n(home_n), .winding_a_level(al),
    .winding_a_negative(an), .winding_b_level(bl), .winding_b_negative(bn),
    .winding_a_out_pos(ap), .winding_a_out_neg(aq),
    .winding_a_out_pos_oe_n(apo), .winding_a_out_neg_oe_n(aqo),
    .winding_b_out_pos(bp), .winding_b_out_neg(bq),
    .winding_b_out_pos_oe_n(bpo), .winding_b_out_neg_oe_n(bqo));

  // signed winding percent at a fine position
  function automatic int wave(input int p);
    int q = p % 8;
    case (p / 8)
      0: return mt[q];
      1: return -mt[8 - q];
      2: return -mt[q];
      default: return mt[8 - q];
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic stop_test;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one-cycle register strobes, read result noted for the monitor
  task automatic wrr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr   <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic rdr(input logic [3:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    @(posedge core_clk);
    rd   <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge core_clk);
    rd <= 1'b0;
  endtask

  // n steps through the controller model; ok says whether they count
  task automatic mv(input logic f, input int n, input bit ok);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      req <= 1'b1;
      fwd <= f;
      @(posedge core_clk);
      req <= 1'b0;
      for (int k = 0; k < 20 && (k < 2 || busy); k++) @(posedge core_clk);
      if (ok) pos = (pos + (f ? 0 : 32) + (f ? 1 : -1) * (8 >> {sh, sl})) % 32;
    end
  endtask

  // status word, home flag and both winding levels
  task automatic st;
    int a = wave(pos);
    int b = wave((pos + 24) % 32);
    rdr(OFS_STATUS, 32'({eoc[0], pos == 4, pos[4:0]}), 32'h7f);
    chk(32'({home_n, an, al, bn, bl}), 32'({pos != 4, a < 0,
        7'(a < 0 ? -a : a), b < 0, 7'(b < 0 ? -b : b)}));
  endtask

  // read results are compared in the cycle they stand
  always @(posedge core_clk) begin
    if (rd_seen) begin
      em = msk_q.pop_front();
      ev = exp_q.pop_front();
      chk(rdat & em, ev);
    end
    rd_seen <= rd;
  end

  initial begin
    #100000;
    failures++;
    stop_test;
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    st;
    rdr(OFS_MIXED, 32'(MIXED_RST), 32'hffffffff);
    for (int i = 0; i < 4; i++) begin
      wrr(OFS_CTRL, 32'hfffffffc | 32'(i));
      rdr(OFS_CTRL, 32'(i), 32'hffffffff);
    end
    wrr(4'hc, 32'h1);
    rdr(4'hc, 32'h0, 32'hffffffff);
    wrr(OFS_CTRL, 32'h0);
    // each step size, forward then back; all but eighth step cross the wrap
    for (int s = 0; s < 4; s++) begin
      {sh, sl} <= 2'(s);
      mv(1, 4, 1);
      st;
      mv(0, 5, 1);
      st;
    end
    // every table entry forward, then every one in reverse
    for (int i = 0; i < 66; i++) begin
      mv(i < 33, 1, 1);
      st;
    end
    // clear holds home and drops steps
    mv(1, 3, 1);
    clr_n <= 1'b0;
    pos = 4;
    mv(1, 2, 0);
    st;
    clr_n <= 1'b1;
    // low power drops steps
    mv(1, 2, 1);
    lp_n <= 1'b0;
    mv(0, 3, 0);
    lp_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    st;
    // supply then temperature fault: home, steps dropped, resume
    for (int i = 0; i < 2; i++) begin
      mv(1, 3, 1);
      {ot, uv} <= 2'(1 << i);
      pos = 4;
      mv(1, 2, 0);
      {ot, uv} <= 2'h0;
      mv(0, 1, 1);
      st;
    end
    // enable with trips held: blanking drives, then slow decay
    ca    <= 1'b1;
    cb    <= 1'b1;
    drv_n <= 1'b0;
    repeat (100) @(posedge core_clk);
    chk(32'({apo, aqo, ap, aq, bpo, bqo, bp, bq}), 32'h22);
    repeat (148) @(posedge core_clk);
    chk(32'({apo, aqo, ap, aq, bpo, bqo, bp, bq}), 32'h00);
    // fast decay reverses only the winding whose current fell
    wrr(OFS_CTRL, 32'(DECAY_FAST));
    repeat (260) @(posedge core_clk);
    chk(32'({apo, aqo, ap, aq, bpo, bqo, bp, bq}), 32'h01);
    // overcurrent homes and latches bridges off until re-enable
    mv(1, 2, 1);
    oc <= 1'b1;
    @(posedge core_clk);
    oc  <= 1'b0;
    pos = 4;
    eoc = 1;
    st;
    chk(32'({apo, aqo, bpo, bqo}), 32'hf);
    drv_n <= 1'b1;
    mv(1, 2, 1);
    st;
    drv_n <= 1'b0;
    eoc = 0;
    st;
    // random walk with comparator noise
    for (int i = 0; i < 30; i++) begin
      ca <= 1'($random(seed));
      cb <= 1'($random(seed));
      mv(1'($random(seed)), 1 + int'($unsigned($random(seed)) % 4), 1);
      st;
    end
    repeat (4) @(posedge core_clk);
    stop_test;
  end
endmodule
`default_nettype wire
